// ### verification/sensor_host_model.sv
// Bus controller model that clocks the sensor's serial port
`timescale 1ns/10ps
module sensor_host_model (
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic host_oe
);
   // Idle bus: both lines released
   initial
   begin
      scl = 1'b1;
      host_oe = 1'b0;
   end
   // One bit: data set while clock low, sampled in the high phase
   task automatic bit_x(input logic b, output logic r);
      @(negedge clk) host_oe = !b;
      @(negedge clk) scl = 1'b1;
      @(negedge clk) r = sda;
      @(negedge clk) scl = 1'b0;
   endtask
   // Start or repeated start; data is released first so it can fall with clock high
   task automatic start();
      @(negedge clk) host_oe = 1'b0;
      @(negedge clk) scl = 1'b1;
      @(negedge clk) host_oe = 1'b1;
      @(negedge clk) scl = 1'b0;
   endtask
   task automatic stop();
      @(negedge clk) host_oe = 1'b1;
      @(negedge clk) scl = 1'b1;
      @(negedge clk) host_oe = 1'b0;
   endtask
   // Eight bits out and in, then the acknowledge bit
   task automatic xbyte(input logic [7:0] o, input logic a, output logic [7:0] i, output logic r);
      for (int k = 7; k >= 0; k--)
      begin
         bit_x(o[k], i[k]);
      end
      bit_x(a, r);
   endtask
endmodule

// ### verification/sensor_host_port_assertions.sv
// Port assertions for the sensor host port
`timescale 1ns/10ps
module sensor_host_port_assertions #(
   parameter int INIT_TIME_US = 1000
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic link_clk,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic int_out,
   input wire logic int_oe,
   input wire logic conversion_active,
   input wire logic [1:0] conversion_channel
);
   localparam int INIT_CYC = INIT_TIME_US * 10;
   logic [15:0] seg;
   logic [15:0] boot;
   logic [7:0] gap;
   // Counts: cycles on this channel, since reset, since a conversion ended
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         seg <= 16'h0000;
         boot <= 16'h0000;
         gap <= 8'hff;
      end
      else
      begin
         seg <= (!conversion_active || $changed(conversion_channel)) ? 16'h0000 : seg + 16'h0001;
         boot <= (boot == 16'hffff) ? boot : boot + 16'h0001;
         gap <= $fell(conversion_active) ? 8'h00 : (gap == 8'hff ? gap : gap + 8'h01);
      end
   end
   // A channel's conversion ends when the channel moves on or conversion stops
   sequence seg_end;
      conversion_active && $past(conversion_active) && $changed(conversion_channel) || $fell(conversion_active);
   endsequence
   chk_sda_pull_only: assert property (@(posedge link_clk) disable iff (!rstn) sda_out == 1'b0)
      else $error("sda driven high");
   chk_int_pull_only: assert property (@(posedge clk) disable iff (!rstn) int_out == 1'b0)
      else $error("int driven high");
   // Data may only move while the bus clock is low, else it would look like start or stop
   chk_bus_turnaround: assert property (@(posedge link_clk) disable iff (!rstn) $changed(sda_oe) |-> !scl_in)
      else $error("sda changed with scl high");
   chk_quiet_init: assert property (@(posedge clk) disable iff (!rstn) int'(boot) < INIT_CYC |-> !conversion_active)
      else $error("conversion during init");
   // Shortest conversion is exponent 0: 1550 + 488 + 488 cycles
   chk_conv_length: assert property (@(posedge clk) disable iff (!rstn) seg_end |-> seg >= 16'h09c4)
      else $error("conversion too short");
   chk_chan_ascend: assert property (@(posedge clk) disable iff (!rstn)
      conversion_active && $past(conversion_active) && $changed(conversion_channel)
      |-> conversion_channel > $past(conversion_channel))
      else $error("channel order wrong");
   chk_chan_range: assert property (@(posedge clk) disable iff (!rstn) conversion_active |-> conversion_channel != 2'h3)
      else $error("channel out of range");
   chk_int_cause: assert property (@(posedge clk) disable iff (!rstn) $rose(int_oe) |-> gap <= 8'h0c)
      else $error("interrupt without conversion");
endmodule

// ### verification/sensor_host_port_tb.sv
// Bench for the sensor host port: bus tasks and directed mode tests
`timescale 1ns/10ps
module sensor_host_port_tb;
   localparam int INIT_TIME_US = 10;
   logic clk = 1'b0, link_clk = 1'b0, rstn = 1'b0, strap = 1'b1;
   logic ack, scl, host_oe, sda_out, sda_oe, int_out, int_oe, act;
   logic [1:0] ch;
   logic [15:0] sample = 16'h0000;
   logic [7:0] junk;
   logic [7:0] rb [0:7];
   logic [6:0] dev = 7'h53;
   logic [15:0] run = 16'h0000;
   logic [15:0] last_run = 16'h0000;
   int n_mismatch = 0, compares = 0, cyc = 0;
   wire sda = !(sda_oe || host_oe);
   // Unrelated clocks
   always #50 clk = !clk;
   always #7.5 link_clk = !link_clk;
   // Analog stand-in: a distinct sample per channel
   always @(negedge clk) sample <= {6'h08, ch, 6'h0c, ch};
   // Length of the latest conversion burst in clock cycles, counted where act is settled
   always @(negedge clk)
   begin
      run <= act ? run + 16'h0001 : 16'h0000;
      if (!act && run != 16'h0000)
         last_run <= run;
   end
   sensor_host_port #(.INIT_TIME_US(INIT_TIME_US)) dut_u (.clk(clk), .rstn(rstn), .link_clk(link_clk),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .int_out(int_out), .int_oe(int_oe),
      .second_led_drive_pin(strap), .conversion_result(sample), .conversion_active(act), .conversion_channel(ch));
   sensor_host_model host_u (.clk(clk), .sda(sda), .scl(scl), .host_oe(host_oe));
   task automatic check(input logic [7:0] s, input logic [7:0] e);
      compares++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic final_report();
      if (n_mismatch == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Burst write of the low n bytes of v, first byte the highest of them
   task automatic wr(input logic [7:0] idx, input int n, input logic [55:0] v);
      host_u.start();
      host_u.xbyte({dev, 1'b0}, 1'b1, junk, ack);
      host_u.xbyte(idx, 1'b1, junk, ack);
      for (int k = 0; k < n; k++)
      begin
         host_u.xbyte(v[8 * (n - 1 - k) +: 8], 1'b1, junk, ack);
      end
      host_u.stop();
   endtask
   // Pointer load, burst read, compare against e
   task automatic rdc(input logic [7:0] idx, input int n, input logic [55:0] e);
      wr(idx, 0, 56'h0);
      host_u.start();
      host_u.xbyte({dev, 1'b1}, 1'b1, junk, ack);
      for (int k = 0; k < n; k++)
      begin
         host_u.xbyte(8'hff, k == n - 1, rb[k], junk);
         check(rb[k], e[8 * (n - 1 - k) +: 8]);
      end
      host_u.stop();
   endtask
   // Bounded wait for the interrupt pin
   task automatic wait_int(input int lim);
      for (int k = 0; k < lim && int_oe !== 1'b1; k++)
      begin
         @(negedge clk);
      end
      check({7'h00, int_oe}, 8'h01);
   endtask
   // Hang guard above the planned run length
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 80000)
      begin
         n_mismatch++;
         final_report();
      end
   end
   initial
   begin
      repeat (8) @(negedge clk);
      rstn = 1'b1;
      repeat (INIT_TIME_US * 10 + 20) @(negedge clk);
      rdc(8'h00, 2, 56'h5a00);
      rdc(8'h11, 1, 56'h01);
      wr(8'h01, 5, 56'h0700010400);
      rdc(8'h01, 5, 56'h0700010400);
      rdc(8'h41, 3, 56'h070707);
      wr(8'h0f, 1, 56'h01);
      wr(8'h0b, 1, 56'h11);
      wait_int(9000);
      // Three channels at exponent 0 back to back: 3 * (1550 + 488 + 488) cycles
      check(last_run[15:8], 8'h1d);
      check(last_run[7:0], 8'h9a);
      rdc(8'h12, 7, 56'h01203021312232);
      rdc(8'h11, 1, 56'h01);
      check({7'h00, int_oe}, 8'h01);
      wr(8'h12, 1, 56'h01);
      repeat (10) @(negedge clk);
      check({7'h00, int_oe}, 8'h00);
      wr(8'h0f, 1, 56'h00);
      wr(8'h0b, 1, 56'h11);
      repeat (9000) @(negedge clk);
      check({7'h00, int_oe}, 8'h00);
      rdc(8'h12, 1, 56'h01);
      wr(8'h12, 1, 56'h01);
      wr(8'h01, 6, 56'h01010104011f);
      wr(8'h0f, 1, 56'h06);
      wr(8'h0b, 1, 56'h13);
      wait_int(9000);
      // One channel at exponent 1: 1550 + 488 + 976 cycles
      check(last_run[15:8], 8'h0b);
      check(last_run[7:0], 8'hc6);
      rdc(8'h12, 3, 56'h062030);
      wr(8'h12, 1, 56'h06);
      wait_int(9000);
      wr(8'h0b, 1, 56'h12);
      repeat (6000) @(negedge clk);
      rdc(8'h11, 1, 56'h01);
      wr(8'h0b, 1, 56'h01);
      repeat (INIT_TIME_US * 10 + 20) @(negedge clk);
      rdc(8'h01, 1, 56'h00);
      rdc(8'h11, 1, 56'h01);
      strap = 1'b0;
      rdc(8'h00, 1, 56'h5a);
      rstn = 1'b0;
      repeat (4) @(negedge clk);
      rstn = 1'b1;
      repeat (INIT_TIME_US * 10 + 20) @(negedge clk);
      rdc(8'h00, 1, 56'hff);
      check({7'h00, ack}, 8'h01);
      dev = 7'h52;
      rdc(8'h00, 1, 56'h5a);
      final_report();
   end
endmodule
bind sensor_host_port sensor_host_port_assertions #(.INIT_TIME_US(INIT_TIME_US)) chk_u (.clk(clk), .rstn(rstn),
   .link_clk(link_clk), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .int_out(int_out), .int_oe(int_oe),
   .conversion_active(conversion_active), .conversion_channel(conversion_channel));

// ### verilog/sensor_host_port.sv
// Sensor serial register port (link clock) and measurement mode sequencer (system clock)
`timescale 1ns/10ps
`include "sensor_params.svh"

module sensor_host_port #(
   parameter int INIT_TIME_US = `INIT_TIME_US
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic link_clk,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic int_out,
   output logic int_oe,
   input wire logic second_led_drive_pin,
   input wire logic [15:0] conversion_result,
   output logic conversion_active,
   output logic [1:0] conversion_channel
);

   localparam int INIT_CYC = INIT_TIME_US * 1000 / `CLK_PERIOD_NS;

   // ---------------- link domain ----------------
   logic [1:0] lrst;
   logic lrstn;
   logic [1:0] scl_m;
   logic [1:0] sda_m;
   logic scl_d;
   logic sda_d;
   logic start_c;
   logic stop_c;
   logic rise;
   logic fall;
   sensor_pkg::link_e lstate;
   logic [3:0] bit_cnt;
   logic ack;
   logic rw;
   logic nack;
   logic [7:0] sh;
   logic [7:0] tx;
   logic [5:0] ptr;
   logic inhibit;
   logic wr_pulse;
   logic [5:0] wr_idx;
   logic [7:0] wr_data;
   logic [7:0] rd_byte;
   logic [6:0] my_addr;
   sensor_pkg::cfg_s cfg_l;
   logic [7:0] cmd_code;
   logic cmd_tgl;
   logic [2:0] clr_mask;
   logic clr_tgl;
   logic [1:0] alt_m;
   logic [2:0] res_tm;
   sensor_pkg::results_t res_l;
   logic [2:0] stat_m1;
   logic [2:0] stat_l;
   logic [3:0] mode_m1;
   logic [3:0] mode_l;

   // ---------------- clock domain ----------------
   sensor_pkg::mode_e state;
   logic [23:0] cnt;
   logic autonomous;
   logic [2:0] mask;
   logic [1:0] ch;
   logic thr_hit;
   logic addr_alt;
   logic [1:0] led_m;
   sensor_pkg::cfg_s cfg_m1;
   sensor_pkg::cfg_s cfg_c;
   logic [2:0] cmd_m;
   logic [2:0] clr_m;
   logic cmd_evt;
   logic clr_evt;
   logic [2:0] set_bits;
   logic [2:0] status;
   sensor_pkg::results_t res;
   logic res_tgl;
   logic [2:0] force_mask;
   logic [2:0] auto_mask;
   logic [2:0] rest_mask;
   logic [23:0] period_cyc;

   function automatic logic [1:0] first_set(input logic [2:0] m);
      first_set = 2'h0;
      for (int i = 2; i >= 0; i--)
      begin
         if (m[i])
            first_set = 2'(i);
      end
   endfunction

   // Link reset release is synchronised so the state machine never leaves reset mid-edge
   always_ff @(posedge link_clk or negedge rstn)
   begin
      if (!rstn)
         lrst <= 2'h0;
      else
         lrst <= {lrst[0], 1'b1};
   end
   assign lrstn = lrst[1];

   // Bus pins pass two flops; a third stage gives edge history
   always_ff @(posedge link_clk or negedge lrstn)
   begin
      if (!lrstn)
      begin
         scl_m <= 2'h3;
         sda_m <= 2'h3;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end
      else
      begin
         scl_m <= {scl_m[0], scl_in};
         sda_m <= {sda_m[0], sda_in};
         scl_d <= scl_m[1];
         sda_d <= sda_m[1];
      end
   end
   assign start_c = scl_m[1] & scl_d & sda_d & ~sda_m[1];
   assign stop_c = scl_m[1] & scl_d & ~sda_d & sda_m[1];
   assign rise = scl_m[1] & ~scl_d;
   assign fall = ~scl_m[1] & scl_d;

   // Address strap arrives from the clock domain as a fixed level
   always_ff @(posedge link_clk or negedge lrstn)
   begin
      if (!lrstn)
         alt_m <= 2'h0;
      else
         alt_m <= {alt_m[0], addr_alt};
   end
   assign my_addr = alt_m[1] ? `ADDR_ALTERNATE : `ADDR_DEFAULT;

   // Read data for the current pointer; status directly precedes results
   always_comb
   begin
      rd_byte = 8'h00;
      if (ptr >= `REG_OUT0 && ptr < `REG_OUT0 + `OUT_BYTES)
         rd_byte = res_l[3'(ptr - `REG_OUT0) >> 1][((ptr[0] == `REG_OUT0 % 2) ? 15 : 7) -: 8];
      else
      begin
         unique case (ptr)
            `REG_ID: rd_byte = `ID_VALUE;
            `REG_CHAN_EN: rd_byte = {5'h00, cfg_l.chan_en};
            `REG_RATE_SEL: rd_byte = {5'h00, cfg_l.rate_sel};
            `REG_MULT: rd_byte = cfg_l.multiplier;
            `REG_PERIOD: rd_byte = cfg_l.period;
            `REG_EXPONENT: rd_byte = {4'h0, cfg_l.exponent};
            `REG_THRESHOLD: rd_byte = cfg_l.threshold;
            `REG_COMMAND: rd_byte = cmd_code;
            `REG_IRQ_ENABLE: rd_byte = {5'h00, cfg_l.irq_enable};
            `REG_RESPONSE: rd_byte = {4'h0, mode_l};
            `REG_IRQ_STATUS: rd_byte = {5'h00, stat_l};
            default: rd_byte = 8'h00;
         endcase
      end
   end

   // Serial target; pointer, ack and data drive are all decided on falling clock edges
   always_ff @(posedge link_clk or negedge lrstn)
   begin
      if (!lrstn)
      begin
         lstate <= sensor_pkg::I_IDLE;
         bit_cnt <= 4'h0;
         ack <= 1'b0;
         rw <= 1'b0;
         nack <= 1'b0;
         sh <= 8'h00;
         tx <= 8'h00;
         ptr <= 6'h00;
         inhibit <= 1'b0;
         sda_oe <= 1'b0;
         wr_pulse <= 1'b0;
         wr_idx <= 6'h00;
         wr_data <= 8'h00;
      end
      else
      begin
         wr_pulse <= 1'b0;
         if (start_c)
         begin
            lstate <= sensor_pkg::I_ADDR;
            bit_cnt <= 4'h0;
            ack <= 1'b0;
            sda_oe <= 1'b0;
         end
         else if (stop_c)
         begin
            lstate <= sensor_pkg::I_IDLE;
            sda_oe <= 1'b0;
         end
         else if (lstate == sensor_pkg::I_RD)
         begin
            if (rise && ack)
               nack <= sda_m[1];
            if (fall && !ack)
            begin
               if (bit_cnt < 4'h8)
               begin
                  sda_oe <= ~tx[6];
                  tx <= {tx[6:0], 1'b0};
                  bit_cnt <= bit_cnt + 4'h1;
               end
               else
               begin
                  sda_oe <= 1'b0;
                  ack <= 1'b1;
               end
            end
            else if (fall && ack)
            begin
               ack <= 1'b0;
               if (nack)
                  lstate <= sensor_pkg::I_IDLE;
               else
               begin
                  tx <= rd_byte;
                  sda_oe <= ~rd_byte[7];
                  bit_cnt <= 4'h1;
                  ptr <= inhibit ? ptr : ptr + 6'h1;
               end
            end
         end
         else if (lstate != sensor_pkg::I_IDLE)
         begin
            if (rise && !ack && bit_cnt < 4'h8)
            begin
               sh <= {sh[6:0], sda_m[1]};
               bit_cnt <= bit_cnt + 4'h1;
            end
            else if (fall && !ack && bit_cnt == 4'h8)
            begin
               unique case (lstate)
                  sensor_pkg::I_ADDR:
                  begin
                     if (sh[7:1] == my_addr)
                     begin
                        ack <= 1'b1;
                        sda_oe <= 1'b1;
                        rw <= sh[0];
                     end
                     else
                        lstate <= sensor_pkg::I_IDLE;
                  end
                  sensor_pkg::I_REG:
                  begin
                     ptr <= sh[`REG_IDX_MSB:0];
                     inhibit <= sh[`AI_BIT];
                     ack <= 1'b1;
                     sda_oe <= 1'b1;
                  end
                  default:
                  begin
                     wr_pulse <= 1'b1;
                     wr_idx <= ptr;
                     wr_data <= sh;
                     ptr <= inhibit ? ptr : ptr + 6'h1;
                     ack <= 1'b1;
                     sda_oe <= 1'b1;
                  end
               endcase
            end
            else if (fall && ack)
            begin
               ack <= 1'b0;
               bit_cnt <= 4'h0;
               sda_oe <= 1'b0;
               nack <= 1'b0;
               if (lstate == sensor_pkg::I_ADDR && rw)
               begin
                  lstate <= sensor_pkg::I_RD;
                  tx <= rd_byte;
                  sda_oe <= ~rd_byte[7];
                  bit_cnt <= 4'h1;
                  ptr <= inhibit ? ptr : ptr + 6'h1;
               end
               else if (lstate == sensor_pkg::I_ADDR)
                  lstate <= sensor_pkg::I_REG;
               else
                  lstate <= sensor_pkg::I_WR;
            end
         end
      end
   end

   // Host-written registers; a software reset wipes configuration while initializing
   always_ff @(posedge link_clk or negedge lrstn)
   begin
      if (!lrstn)
      begin
         cfg_l <= '0;
         cmd_code <= 8'h00;
         cmd_tgl <= 1'b0;
         clr_mask <= 3'h0;
         clr_tgl <= 1'b0;
      end
      else if (mode_l[3])
         cfg_l <= '0;
      else if (wr_pulse)
      begin
         unique case (wr_idx)
            `REG_CHAN_EN: cfg_l.chan_en <= wr_data[2:0];
            `REG_RATE_SEL: cfg_l.rate_sel <= wr_data[2:0];
            `REG_MULT: cfg_l.multiplier <= wr_data;
            `REG_PERIOD: cfg_l.period <= wr_data;
            `REG_EXPONENT: cfg_l.exponent <= wr_data[3:0];
            `REG_THRESHOLD: cfg_l.threshold <= wr_data;
            `REG_IRQ_ENABLE: cfg_l.irq_enable <= wr_data[2:0];
            `REG_COMMAND:
            begin
               cmd_code <= wr_data;
               cmd_tgl <= ~cmd_tgl;
            end
            `REG_IRQ_STATUS:
            begin
               clr_mask <= wr_data[2:0];
               clr_tgl <= ~clr_tgl;
            end
            default: ;
         endcase
      end
   end

   // Results and status come over; a toggle marks a fresh, stable result set
   always_ff @(posedge link_clk or negedge lrstn)
   begin
      if (!lrstn)
      begin
         res_tm <= 3'h0;
         res_l <= '0;
         stat_m1 <= 3'h0;
         stat_l <= 3'h0;
         mode_m1 <= 4'h0;
         mode_l <= 4'h0;
      end
      else
      begin
         res_tm <= {res_tm[1:0], res_tgl};
         if (res_tm[2] != res_tm[1])
            res_l <= res;
         stat_m1 <= status;
         stat_l <= stat_m1;
         mode_m1 <= {state == sensor_pkg::M_INIT, conversion_active, autonomous, state == sensor_pkg::M_STANDBY};
         mode_l <= mode_m1;
      end
   end

   // ---------------- clock domain ----------------

   // Configuration is quasi-static, commands and clears are toggle events
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cfg_m1 <= '0;
         cfg_c <= '0;
         cmd_m <= 3'h0;
         clr_m <= 3'h0;
         led_m <= 2'h3;
      end
      else
      begin
         cfg_m1 <= cfg_l;
         cfg_c <= cfg_m1;
         cmd_m <= {cmd_m[1:0], cmd_tgl};
         clr_m <= {clr_m[1:0], clr_tgl};
         led_m <= {led_m[0], second_led_drive_pin};
      end
   end
   assign cmd_evt = cmd_m[2] != cmd_m[1];
   assign clr_evt = clr_m[2] != clr_m[1];
   assign force_mask = cfg_c.chan_en & ~cfg_c.rate_sel;
   assign auto_mask = cfg_c.chan_en & cfg_c.rate_sel & {3{cfg_c.multiplier != 8'h00}};
   assign rest_mask = mask & ~(3'h1 << ch);
   assign period_cyc = 24'((cfg_c.period == 8'h00 ? 8'h01 : cfg_c.period) * `PERIOD_TICK_CYC);

   // Mode sequencer; bus traffic alone never moves it out of standby
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= sensor_pkg::M_OFF;
         cnt <= 24'h0;
         autonomous <= 1'b0;
         mask <= 3'h0;
         ch <= 2'h0;
         thr_hit <= 1'b0;
         addr_alt <= 1'b0;
         set_bits <= 3'h0;
      end
      else
      begin
         set_bits <= 3'h0;
         if (cmd_evt && cmd_code == `CMD_RESET_SW && state != sensor_pkg::M_OFF && state != sensor_pkg::M_INIT)
            state <= sensor_pkg::M_OFF;
         else
         begin
            if (cmd_evt && cmd_code == `CMD_PAUSE)
               autonomous <= 1'b0;
            unique case (state)
               sensor_pkg::M_OFF:
               begin
                  autonomous <= 1'b0;
                  cnt <= 24'(INIT_CYC - 1);
                  state <= sensor_pkg::M_INIT;
               end
               sensor_pkg::M_INIT:
               begin
                  if (cnt == 24'h0)
                  begin
                     addr_alt <= ~led_m[1];
                     state <= sensor_pkg::M_STANDBY;
                  end
                  else
                     cnt <= cnt - 24'h1;
               end
               sensor_pkg::M_STANDBY:
               begin
                  if (cmd_evt && cmd_code == `CMD_FORCE && force_mask != 3'h0)
                  begin
                     mask <= force_mask;
                     ch <= first_set(force_mask);
                     thr_hit <= 1'b0;
                     cnt <= 24'(`CTRL_SETUP_CYC - 1);
                     state <= sensor_pkg::M_CTRL;
                  end
                  else if (cmd_evt && cmd_code == `CMD_START)
                  begin
                     autonomous <= 1'b1;
                     cnt <= period_cyc - 24'h1;
                     state <= sensor_pkg::M_SLEEP;
                  end
               end
               sensor_pkg::M_SLEEP:
               begin
                  if (!autonomous)
                     state <= sensor_pkg::M_STANDBY;
                  else if (cnt != 24'h0)
                     cnt <= cnt - 24'h1;
                  else if (auto_mask != 3'h0)
                  begin
                     mask <= auto_mask;
                     ch <= first_set(auto_mask);
                     thr_hit <= 1'b0;
                     cnt <= 24'(`CTRL_SETUP_CYC - 1);
                     state <= sensor_pkg::M_CTRL;
                  end
                  else
                     cnt <= period_cyc - 24'h1;
               end
               sensor_pkg::M_CTRL:
               begin
                  if (cnt == 24'h0)
                  begin
                     cnt <= 24'(`ADC_SETUP_CYC - 1);
                     state <= sensor_pkg::M_ADC;
                  end
                  else
                     cnt <= cnt - 24'h1;
               end
               sensor_pkg::M_ADC:
               begin
                  if (cnt == 24'h0)
                  begin
                     cnt <= (24'(`ADC_SETUP_CYC) << cfg_c.exponent) - 24'h1;
                     state <= sensor_pkg::M_INTEG;
                  end
                  else
                     cnt <= cnt - 24'h1;
               end
               sensor_pkg::M_INTEG:
               begin
                  if (cnt != 24'h0)
                     cnt <= cnt - 24'h1;
                  else
                  begin
                     if (conversion_result[15:8] > cfg_c.threshold)
                        thr_hit <= 1'b1;
                     mask <= rest_mask;
                     if (rest_mask != 3'h0)
                     begin
                        ch <= first_set(rest_mask);
                        cnt <= 24'(`CTRL_SETUP_CYC - 1);
                        state <= sensor_pkg::M_CTRL;
                     end
                     else
                        state <= sensor_pkg::M_DONE;
                  end
               end
               sensor_pkg::M_DONE:
               begin
                  set_bits[`IRQ_FORCE_BIT] <= ~autonomous;
                  set_bits[`IRQ_AUTO_BIT] <= autonomous;
                  set_bits[`IRQ_THRESH_BIT] <= autonomous & thr_hit;
                  cnt <= period_cyc - 24'h1;
                  state <= autonomous ? sensor_pkg::M_SLEEP : sensor_pkg::M_STANDBY;
               end
            endcase
         end
      end
   end

   // Result capture; the toggle flips only once the whole set has settled
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         res <= '0;
         res_tgl <= 1'b0;
      end
      else
      begin
         if (state == sensor_pkg::M_INTEG && cnt == 24'h0)
            res[ch] <= conversion_result;
         if (state == sensor_pkg::M_DONE)
            res_tgl <= ~res_tgl;
      end
   end

   // Sticky status; a new event beats a simultaneous host clear
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         status <= 3'h0;
      else if (state == sensor_pkg::M_OFF)
         status <= 3'h0;
      else
         status <= (status & ~(clr_evt ? clr_mask : 3'h0)) | set_bits;
   end

   // Pin drivers; data lines only ever pull low, so the driven level is constant
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         int_oe <= 1'b0;
         int_out <= 1'b0;
         conversion_active <= 1'b0;
         conversion_channel <= 2'h0;
      end
      else
      begin
         int_oe <= |(status & cfg_c.irq_enable);
         int_out <= 1'b0;
         conversion_active <= state == sensor_pkg::M_CTRL || state == sensor_pkg::M_ADC
            || state == sensor_pkg::M_INTEG;
         conversion_channel <= ch;
      end
   end

   // Serial data line likewise only pulls low
   always_ff @(posedge link_clk or negedge lrstn)
   begin
      if (!lrstn)
         sda_out <= 1'b0;
      else
         sda_out <= 1'b0;
   end

endmodule

// ### verilog/sensor_params.svh
// Register offsets, field positions, command codes and timing counts of the sensor host port
`ifndef SENSOR_PARAMS_SVH
`define SENSOR_PARAMS_SVH

// Target addresses; the alternate one is chosen by the strap pin held low
`define ADDR_DEFAULT 7'h53
`define ADDR_ALTERNATE 7'h52

// Register address byte layout
`define REG_IDX_MSB 5
`define AI_BIT 6

// Register indices
`define REG_ID 6'h00
`define REG_CHAN_EN 6'h01
`define REG_RATE_SEL 6'h02
`define REG_MULT 6'h03
`define REG_PERIOD 6'h04
`define REG_EXPONENT 6'h05
`define REG_THRESHOLD 6'h06
`define REG_COMMAND 6'h0b
`define REG_IRQ_ENABLE 6'h0f
`define REG_RESPONSE 6'h11
`define REG_IRQ_STATUS 6'h12
`define REG_OUT0 6'h13
`define OUT_BYTES 6

// Identification byte, value arbitrary
`define ID_VALUE 8'h5a

// Command codes
`define CMD_RESET_SW 8'h01
`define CMD_FORCE 8'h11
`define CMD_PAUSE 8'h12
`define CMD_START 8'h13

// Interrupt status bits
`define IRQ_FORCE_BIT 0
`define IRQ_AUTO_BIT 1
`define IRQ_THRESH_BIT 2

// Timing
`define CLK_PERIOD_NS 100
`define CTRL_SETUP_NS 155000
`define ADC_SETUP_NS 48800
`define PERIOD_TICK_NS 100000
`define INIT_TIME_US 1000
`define CTRL_SETUP_CYC ((`CTRL_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADC_SETUP_CYC ((`ADC_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PERIOD_TICK_CYC ((`PERIOD_TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### verilog/sensor_pkg.sv
// Types shared by the sensor host port
package sensor_pkg;

   typedef enum {M_OFF, M_INIT, M_STANDBY, M_CTRL, M_ADC, M_INTEG, M_DONE, M_SLEEP} mode_e;

   typedef enum {I_IDLE, I_ADDR, I_REG, I_WR, I_RD} link_e;

   typedef struct packed {
      logic [7:0] threshold;
      logic [3:0] exponent;
      logic [7:0] period;
      logic [7:0] multiplier;
      logic [2:0] rate_sel;
      logic [2:0] chan_en;
      logic [2:0] irq_enable;
   } cfg_s;

   typedef logic [2:0][15:0] results_t;

endpackage
